// ===== sync_sram_regs.svh
`ifndef SYNC_SRAM_REGS_SVH
`define SYNC_SRAM_REGS_SVH

// ----------------------------------------------------------------------
// Burst order and burst length
// ----------------------------------------------------------------------
`define SRAM_MODE_LINEAR 1'b0
`define SRAM_MODE_INTERLEAVED 1'b1
`define SRAM_BURST_W 2

// ----------------------------------------------------------------------
// Power-up wait before the first access
// ----------------------------------------------------------------------
`define SRAM_POWER_UP_US 1000
`define SRAM_CLK_KHZ 10000
`define SRAM_POWER_UP_CYCLES ((`SRAM_POWER_UP_US * `SRAM_CLK_KHZ + 999) / 1000)

`endif

// ===== sync_sram_pkg.sv
package sync_sram_pkg;

  typedef enum logic [1:0]
  {
    OP_IDLE,
    OP_READ,
    OP_WRITE
  } op_type;

endpackage

// ===== burst_if.sv
`timescale 1ns/100ps
`default_nettype none
`include "sync_sram_regs.svh"

interface burst_if;
  logic [`SRAM_BURST_W-1:0] base_low;
  logic [`SRAM_BURST_W-1:0] count;
  logic interleaved;
  logic [`SRAM_BURST_W-1:0] next_low;

  modport user
  (
    output base_low,
    output count,
    output interleaved,
    input next_low
  );

  modport step
  (
    input base_low,
    input count,
    input interleaved,
    output next_low
  );
endinterface

`default_nettype wire

// ===== burst_step.sv
`timescale 1ns/100ps
`default_nettype none
`include "sync_sram_regs.svh"

module burst_step
(
  burst_if.step bus
);

  // --------------------------------------------------------------------
  // Burst address sequencing
  // --------------------------------------------------------------------
  always_comb
  begin
    // R1: linear or interleaved
    if (bus.interleaved == `SRAM_MODE_INTERLEAVED)
    begin
      bus.next_low = bus.base_low ^ bus.count;
    end
    else
    begin
      bus.next_low = `SRAM_BURST_W'(bus.base_low + bus.count);
    end
  end

endmodule

`default_nettype wire

// ===== sync_sram_cycle_control.sv
// Functional notes
// R1: Burst addresses follow linear order when mode is 0, interleaved when 1.
// R2: Cycle enable high means the edge is ignored and the access state holds; synchronizers, power-up count and sleep drop still act.
// R3: No array write happens during a stalled cycle.
// R4: Controller deselects the device before raising the sleep request.
// R5: Data pins stay released when leaving sleep mode.
// R6: Controller waits the power-up interval before its first read or write.
// R7: Selected only when select a low, select b high, select c low.
`timescale 1ns/100ps
`default_nettype none
`include "sync_sram_regs.svh"

module sync_sram_cycle_control
#(
  parameter int ADDR_W = 18,
  parameter int DATA_W = 18,
  parameter int LANES = 2,
  parameter int POWER_UP_CYCLES = `SRAM_POWER_UP_CYCLES
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic advance_load_i,
  input wire logic write_enable_low_i,
  input wire logic [LANES-1:0] byte_write_low_i,
  input wire logic cycle_enable_low_i,
  input wire logic select_a_low_i,
  input wire logic select_b_high_i,
  input wire logic select_c_low_i,
  input wire logic sleep_request_i,
  input wire logic burst_mode_i,
  input wire logic [DATA_W-1:0] data_in_i,
  output logic [DATA_W-1:0] data_o,
  output logic data_oe_o,
  output logic ready_o,
  output logic asleep_o
);

  localparam int LANE_W = DATA_W / LANES;
  localparam int PW = $clog2(POWER_UP_CYCLES + 1);
  localparam int DEPTH = 2 ** ADDR_W;

  // --------------------------------------------------------------------
  // Parameter checks
  // --------------------------------------------------------------------
  initial
  begin
    if (ADDR_W < `SRAM_BURST_W || LANES < 1 || DATA_W % LANES != 0 || POWER_UP_CYCLES < 1)
    begin
      $error("Unsupported parameter set.");
    end
  end

  typedef struct packed {
    logic sleep_meta;
    logic sleep_sync;
    logic mode_meta;
    logic mode_sync;
    logic [PW-1:0] power_cnt;
    logic ready;
    sync_sram_pkg::op_type op;
    logic [ADDR_W-1:0] base;
    logic [`SRAM_BURST_W-1:0] count;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0] lanes;
    logic [DATA_W-1:0] rd_data;
    logic oe;
  } state_type;

  state_type s_q;
  state_type s_d;
  logic [DATA_W-1:0] mem [DEPTH];
  logic enabled;
  logic selected;
  logic load;
  logic advance;
  logic write_now;
  logic [ADDR_W-1:0] nxt_base;
  logic [`SRAM_BURST_W-1:0] nxt_count;
  logic [ADDR_W-1:0] nxt_addr;
  logic [DATA_W-1:0] rd_word;

  burst_if bus ();

  function automatic logic [DATA_W-1:0] merge_lanes(input logic [DATA_W-1:0] old_word,
                                                    input logic [DATA_W-1:0] new_word,
                                                    input logic [LANES-1:0] lanes);
    logic [DATA_W-1:0] merged;
    merged = old_word;
    for (int i = 0; i < DATA_W; i++)
    begin
      if (lanes[i / LANE_W])
      begin
        merged[i] = new_word[i];
      end
    end
    return merged;
  endfunction

  // --------------------------------------------------------------------
  // Cycle qualification
  // --------------------------------------------------------------------
  // R2: stall ignores edge
  assign enabled = ~cycle_enable_low_i & s_q.ready & ~s_q.sleep_sync;
  // R7: select decode
  assign selected = ~select_a_low_i & select_b_high_i & ~select_c_low_i;
  assign load = enabled & ~advance_load_i;
  assign advance = enabled & advance_load_i & (s_q.op != sync_sram_pkg::OP_IDLE);
  // R3: write only when enabled
  assign write_now = enabled & (s_q.op == sync_sram_pkg::OP_WRITE);

  // --------------------------------------------------------------------
  // Burst address
  // --------------------------------------------------------------------
  assign nxt_base = load ? addr_i : s_q.base;
  assign nxt_count = load ? '0 : (advance ? `SRAM_BURST_W'(s_q.count + 1'b1) : s_q.count);
  assign bus.base_low = nxt_base[`SRAM_BURST_W-1:0];
  assign bus.count = nxt_count;
  // R1: mode selects order
  assign bus.interleaved = s_q.mode_sync;
  assign nxt_addr = {nxt_base[ADDR_W-1:`SRAM_BURST_W], bus.next_low};

  burst_step step_u
  (
    .bus(bus.step)
  );

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    rd_word = mem[nxt_addr];
    if (write_now && s_q.addr == nxt_addr)
    begin
      rd_word = merge_lanes(mem[nxt_addr], data_in_i, s_q.lanes);
    end
    s_d.sleep_meta = sleep_request_i;
    s_d.sleep_sync = s_q.sleep_meta;
    s_d.mode_meta = burst_mode_i;
    s_d.mode_sync = s_q.mode_meta;
    // R6: power-up wait
    if (!s_q.ready)
    begin
      s_d.power_cnt = PW'(s_q.power_cnt + 1'b1);
      if (s_q.power_cnt == PW'(POWER_UP_CYCLES - 1))
      begin
        s_d.ready = 1'b1;
      end
    end
    // R4: sleep drops the cycle
    if (s_q.sleep_sync)
    begin
      s_d.op = sync_sram_pkg::OP_IDLE;
      // R5: released on sleep
      s_d.oe = 1'b0;
    end
    else if (load || advance)
    begin
      s_d.base = nxt_base;
      s_d.count = nxt_count;
      s_d.addr = nxt_addr;
      s_d.lanes = ~byte_write_low_i;
      if (load)
      begin
        case ({selected, write_enable_low_i})
          2'b10:
          begin
            s_d.op = sync_sram_pkg::OP_WRITE;
          end
          2'b11:
          begin
            s_d.op = sync_sram_pkg::OP_READ;
          end
          default:
          begin
            s_d.op = sync_sram_pkg::OP_IDLE;
          end
        endcase
      end
      s_d.oe = (s_d.op == sync_sram_pkg::OP_READ);
      if (s_d.op == sync_sram_pkg::OP_READ)
      begin
        s_d.rd_data = rd_word;
      end
    end
    else if (enabled)
    begin
      s_d.op = sync_sram_pkg::OP_IDLE;
      s_d.oe = 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // State registers and array
  // --------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  always_ff @(posedge clk_i)
  begin
    // R3: stalled edge skips write
    if (write_now)
    begin
      mem[s_q.addr] <= merge_lanes(mem[s_q.addr], data_in_i, s_q.lanes);
    end
  end

  assign data_o = s_q.rd_data;
  assign data_oe_o = s_q.oe;
  assign ready_o = s_q.ready;
  assign asleep_o = s_q.sleep_sync;

endmodule

`default_nettype wire

// ===== sync_sram_cycle_control_chk.sv
`timescale 1ns/100ps
`default_nettype none
module sync_sram_cycle_control_chk
#(
  parameter int ADDR_W = 18,
  parameter int DATA_W = 18,
  parameter int LANES = 2,
  parameter int POWER_UP_CYCLES = 4
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic advance_load_i,
  input wire logic write_enable_low_i,
  input wire logic [LANES-1:0] byte_write_low_i,
  input wire logic cycle_enable_low_i,
  input wire logic select_a_low_i,
  input wire logic select_b_high_i,
  input wire logic select_c_low_i,
  input wire logic sleep_request_i,
  input wire logic burst_mode_i,
  input wire logic [DATA_W-1:0] data_in_i,
  input wire logic [DATA_W-1:0] data_o,
  input wire logic data_oe_o,
  input wire logic ready_o,
  input wire logic asleep_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  wire logic sel = !select_a_low_i && select_b_high_i && !select_c_low_i;
  wire logic load = ready_o && !asleep_o && !cycle_enable_low_i && !advance_load_i;
  wire logic calm = !sleep_request_i && !asleep_o;
  a_stall_holds: assert property (cycle_enable_low_i && calm && !$past(sleep_request_i)
    |=> $stable(data_o) && $stable(data_oe_o)) else $error("output moved on stall");
  a_stall_quiet: assert property (cycle_enable_low_i && !data_oe_o
    |=> !data_oe_o) else $error("drive began on stall");
  a_deselect_quiet: assert property (load && !sel
    |=> !data_oe_o) else $error("drive while deselected");
  a_select_read: assert property (load && sel && write_enable_low_i && calm
    && !$past(sleep_request_i) |=> data_oe_o) else $error("selected read not driven");
  a_wake_released: assert property ($fell(asleep_o) |-> !data_oe_o)
    else $error("drive on sleep exit");
  a_sleep_released: assert property (asleep_o |-> !data_oe_o)
    else $error("drive while asleep");
  a_ready_holds: assert property (ready_o |=> ready_o)
    else $error("ready dropped without reset");
  c_stall_read: cover property (cycle_enable_low_i && data_oe_o);
  c_wake: cover property ($fell(asleep_o));
  c_advance: cover property (ready_o && advance_load_i && !cycle_enable_low_i && data_oe_o);
endmodule
bind sync_sram_cycle_control sync_sram_cycle_control_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W),
  .LANES(LANES), .POWER_UP_CYCLES(POWER_UP_CYCLES)) chk (.*);
`default_nettype wire

// ===== sram_ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none
module sram_ctrl_model
(
  input wire logic clk_i,
  input wire logic ready_i,
  output logic [6:0] ctl_o,
  output logic [17:0] addr_o,
  output logic [17:0] din_o
);
  initial
  begin
    ctl_o = 7'h5a;
    addr_o = 18'h0;
    din_o = 18'h0;
  end
  task automatic cyc(input logic [6:0] c, input logic [17:0] a, input logic [17:0] d);
    ctl_o = c;
    addr_o = a;
    din_o = d;
    @(posedge clk_i);
    #1;
  endtask
  task automatic boot;
    for (int n = 0; n < 20 && !ready_i; n++)
      cyc(7'h1a, ~addr_o, ~din_o);
  endtask
  task automatic nap(input logic z);
    cyc(7'h1a, ~addr_o, ~din_o);
    repeat (3) cyc({6'h0d, z}, ~addr_o, ~din_o);
  endtask
endmodule
`default_nettype wire

// ===== tb_sync_sram_cycle_control.sv
`timescale 1ns/100ps
`default_nettype none
module tb_sync_sram_cycle_control;
  localparam logic [6:0] RD = 7'h14, WR = 7'h04, ADV = 7'h34, STL = 7'h54;
  logic clk_i, rst_i, burst_mode_i, oe, rdy, zz;
  logic [6:0] ctl;
  logic [17:0] addr, din, dout, base, a;
  logic [17:0] mem [int];
  int errors, checks_done, i, m;
  int seed = 85007;
  sync_sram_cycle_control #(.POWER_UP_CYCLES(4)) uut (.clk_i(clk_i), .rst_i(rst_i),
    .addr_i(addr), .advance_load_i(ctl[5]), .write_enable_low_i(ctl[4]),
    .byte_write_low_i(2'b00), .cycle_enable_low_i(ctl[6]), .select_a_low_i(ctl[3]),
    .select_b_high_i(ctl[2]), .select_c_low_i(ctl[1]), .sleep_request_i(ctl[0]),
    .burst_mode_i(burst_mode_i), .data_in_i(din), .data_o(dout), .data_oe_o(oe),
    .ready_o(rdy), .asleep_o(zz));
  sram_ctrl_model ctrl (.clk_i(clk_i), .ready_i(rdy), .ctl_o(ctl), .addr_o(addr), .din_o(din));
  function automatic logic [17:0] rnd();
    return 18'($random(seed));
  endfunction
  function automatic logic [17:0] at(input logic [17:0] b, input int k, input int md);
    return {b[17:2], md != 0 ? b[1:0] ^ 2'(k) : b[1:0] + 2'(k)};
  endfunction
  task automatic check(input logic [17:0] seen, input logic [17:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  initial
  begin
    #200000;
    errors++;
    results;
  end
  initial
  begin
    rst_i = 1'b1;
    burst_mode_i = 1'b0;
    repeat (4) @(posedge clk_i);
    #1 rst_i = 1'b0;
    ctrl.cyc(RD, 18'h0, 18'h0);
    check(18'(oe), 18'h0);
    check(18'(rdy), 18'h0);
    ctrl.boot;
    check(18'(rdy), 18'h1);
    for (m = 0; m < 2; m++)
    begin
      burst_mode_i = m[0];
      base = rnd() | 18'h1;
      for (i = 0; i < 4; i++)
      begin
        a = at(base, i, m);
        mem[a] = rnd();
        ctrl.cyc(WR, a, rnd());
        ctrl.cyc(STL, rnd(), rnd());
        ctrl.cyc(7'h1a, rnd(), mem[a]);
      end
      for (i = 0; i < 4; i++)
      begin
        ctrl.cyc(i != 0 ? ADV : RD, base, rnd());
        check(dout, mem[at(base, i, m)]);
        ctrl.cyc(STL, rnd(), rnd());
        check(dout, mem[at(base, i, m)]);
      end
      $display("burst mode %0d done", m);
    end
    for (i = 0; i < 8; i++)
    begin
      ctrl.cyc({3'b001, 3'(i), 1'b0}, base, rnd());
      check(18'(oe), 18'(i == 2));
    end
    $display("select decode done");
    ctrl.cyc(RD, base, rnd());
    ctrl.nap(1'b1);
    check(18'(zz), 18'h1);
    ctrl.cyc(RD | 7'h01, base, rnd());
    check(18'(oe), 18'h0);
    ctrl.nap(1'b0);
    check(18'(oe), 18'h0);
    ctrl.cyc(RD, base, rnd());
    check(dout, mem[base]);
    $display("sleep done");
    ctrl.cyc(WR, base, rnd());
    ctrl.cyc(STL, rnd(), rnd());
    rst_i = 1'b1;
    ctrl.cyc(STL, rnd(), rnd());
    rst_i = 1'b0;
    check(18'(rdy), 18'h0);
    ctrl.boot;
    ctrl.cyc(RD, base, rnd());
    check(dout, mem[base]);
    $display("stalled write done");
    results;
  end
endmodule
`default_nettype wire
